// ===== design/acq_dio.sv
// digital ports, converter sample capture and analog switch control
//
// Overview of operation
// (RULE_01) sixteen pins form two 8-pin ports, one direction bit per port
// (RULE_02) reading an output port returns the value being driven
// (RULE_03) single-shot read samples pins at request, ignoring the A/D clock
// (RULE_04) clocked input captures pins on the analog sample edge, streams them
// (RULE_05) clocked digital input is refused above a 10 MHz sample rate
// (RULE_06) single-shot write updates output pins at once, ignoring D/A clock
// (RULE_07) clocked output drives pins on D/A clock from channel 1 data word
// (RULE_08) both analog channels are captured on one common A/D strobe
// (RULE_09) each A/D sample is delivered as 12-bit two's complement
// (RULE_10) the data supplier gives D/A samples as 12-bit two's complement
// (RULE_11) first attenuator bank selects 0, 6, 14 or 20 dB
// (RULE_12) second attenuator bank selects bypass or 20 dB independently
// (RULE_13) each analog input has a termination enable bit
// (RULE_14) each analog input has an AC coupling enable bit
// (RULE_15) input-mode digital ports have switchable termination
// (RULE_16) after reset both ports are inputs with drivers off
`include "acq_dio_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module acq_dio (
	input  wire logic                        i_clock,
	input  wire logic                        i_srst,
	// digital pins, three signals per pin
	input  wire logic [`DIO_W-1:0]           i_dio_pin,
	output logic      [`DIO_W-1:0]           o_dio_pin,
	output logic      [`DIO_W-1:0]           o_dio_pin_oe_n,
	// port configuration
	input  wire logic [`DIO_PORTS-1:0]       i_port_dir_out,
	input  wire logic [`DIO_PORTS-1:0]       i_port_term_en,
	output logic      [`DIO_PORTS-1:0]       o_port_term,
	output logic      [`DIO_PORTS-1:0]       o_port_dir_out,
	// single-shot read
	input  wire logic                        i_read_req,
	output logic                             o_read_valid,
	output logic      [`DIO_W-1:0]           o_read_data,
	// single-shot write
	input  wire logic                        i_write_req,
	input  wire logic [`DIO_W-1:0]           i_write_data,
	output logic                             o_write_refused,
	// clocked input stream
	input  wire logic                        i_clocked_in_en,
	input  wire logic [`RATE_W-1:0]          i_sample_rate_hz,
	output logic                             o_clocked_in_active,
	output logic                             o_clocked_in_refused,
	input  wire logic                        i_adc_enable,
	input  wire logic                        i_adc_strobe,
	input  wire logic [`SAMPLE_W-1:0]        i_adc_ch0,
	input  wire logic [`SAMPLE_W-1:0]        i_adc_ch1,
	input  wire logic                        i_adc_offset_binary,
	output logic                             o_adc_ready,
	output logic                             o_stream_valid,
	input  wire logic                        i_stream_ready,
	output logic      [`STREAM_W-1:0]        o_stream_data,
	output logic                             o_overrun,
	input  wire logic                        i_overrun_clear,
	output logic      [`OVERRUN_W-1:0]       o_overrun_count,
	// clocked output from the channel 1 data word
	input  wire logic                        i_clocked_out_en,
	input  wire logic                        i_dac_strobe,
	input  wire logic [`DAC_WORD_W-1:0]      i_dac1_word,
	output logic      [`SAMPLE_W-1:0]        o_dac1_sample,
	// analog switch control
	input  wire acq_dio_pkg::atten1_sel_t    i_atten1_sel,
	input  wire acq_dio_pkg::atten2_sel_t    i_atten2_sel,
	output logic                             o_atten1_6db,
	output logic                             o_atten1_14db,
	output logic                             o_atten2_20db,
	input  wire logic [1:0]                  i_ain_term_en,
	input  wire logic [1:0]                  i_ain_ac_en,
	output logic      [1:0]                  o_ain_term,
	output logic      [1:0]                  o_ain_ac
);
	import acq_dio_pkg::*;

	// port direction and drive state
	// direction is registered so pins and read-back change on one edge
	logic [`DIO_PORTS-1:0] port_dir_out;
	logic [`DIO_W-1:0]     dio_drive;
	logic [`DIO_W-1:0]     next_dio_drive;

	// expands one direction bit per port onto every pin of that port
	function automatic logic [`DIO_W-1:0] port_mask(
		input logic [`DIO_PORTS-1:0] dir
	);
		port_mask = {{`DIO_PORT_W{dir[1]}}, {`DIO_PORT_W{dir[0]}}};
	endfunction : port_mask

	// per port: driven value when output, pin level when input
	function automatic logic [`DIO_W-1:0] pin_view(
		input logic [`DIO_PORTS-1:0] dir,
		input logic [`DIO_W-1:0]     drive,
		input logic [`DIO_W-1:0]     pins
	);
		logic [`DIO_W-1:0] m;
		m        = port_mask(dir);
		pin_view = (drive & m) | (pins & ~m);
	endfunction : pin_view

	// offset binary to two's complement is a flip of the sign bit
	function automatic logic [`SAMPLE_W-1:0] to_twos(
		input logic [`SAMPLE_W-1:0] raw,
		input logic                 offset_binary
	);
		to_twos = offset_binary ? {~raw[`SAMPLE_W-1], raw[`SAMPLE_W-2:0]}
		                        : raw;
	endfunction : to_twos

	// shared by the pin drivers, the single read and the stream capture
	wire [`DIO_W-1:0] drive_mask = port_mask(port_dir_out); // [RULE_01]
	wire [`DIO_W-1:0] pin_value  =
		pin_view(port_dir_out, dio_drive, i_dio_pin); // [RULE_02]

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			port_dir_out <= `DIO_RESET_DIR; // [RULE_16]
		end else begin
			port_dir_out <= i_port_dir_out; // [RULE_01]
		end
	end

	assign o_port_dir_out = port_dir_out;
	// pin drivers enable only on output ports; low enable means driving
	assign o_dio_pin_oe_n = ~drive_mask; // [RULE_16]
	assign o_dio_pin      = dio_drive;

	// termination only means something on a port that listens
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_port_term <= '0;
		end else begin
			o_port_term <= i_port_term_en & ~i_port_dir_out; // [RULE_15]
		end
	end

	// output drive: single-shot write or clocked from the D/A word
	// one register owns the pins so the two write paths cannot fight
	// a strobe and a write in one cycle: the strobe wins in clocked output mode, the write otherwise
	wire dac_take   = i_clocked_out_en && i_dac_strobe;
	wire write_take = i_write_req && !i_clocked_out_en;

	// in clocked mode the D/A word owns the pins, so a software write
	// would be overwritten on the next strobe; it is refused instead
	wire [`DIO_W-1:0] dac_dio = i_dac1_word[`DAC_DIO_LSB +: `DIO_W];

	always_comb begin
		next_dio_drive = dio_drive;
		if (dac_take) begin
			next_dio_drive = dac_dio; // [RULE_07]
		end else if (write_take) begin
			next_dio_drive = i_write_data; // [RULE_06]
		end
	end

	// reset clears the drive value so a later switch to output never
	// exposes a stale pattern on the pins
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			dio_drive <= `DIO_RESET_DRIVE;
		end else begin
			dio_drive <= next_dio_drive;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_write_refused <= 1'b0;
			o_dac1_sample   <= '0;
		end else begin
			o_write_refused <= i_write_req && i_clocked_out_en;
			if (dac_take) begin
				// analog half of the same word; supplier gives two's complement
				o_dac1_sample <= i_dac1_word[`DAC_SAMPLE_LSB +: `SAMPLE_W]; // [RULE_10]
			end
		end
	end

	// single-shot read, independent of the sample clock
	// any cycle may read; the data holds until the next request
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_read_valid <= 1'b0;
			o_read_data  <= '0;
		end else begin
			o_read_valid <= i_read_req;
			if (i_read_req) begin
				o_read_data <= pin_value; // [RULE_03] [RULE_02]
			end
		end
	end

	// clocked input mode
	// the rate check guards the host link, not the converters
	// the state register drives the active and refused flags directly
	stream_state_t state;
	stream_state_t next_state;

	wire rate_ok = (i_sample_rate_hz <= `DIO_IN_MAX_RATE_HZ); // [RULE_05]

	always_comb begin
		case (state)
			ST_IDLE: begin
				if (!i_clocked_in_en) begin
					next_state = ST_IDLE;
				end else if (rate_ok) begin
					next_state = ST_RUN;
				end else begin
					next_state = ST_REFUSED;
				end
			end
			ST_RUN: begin
				if (!i_clocked_in_en) begin
					next_state = ST_IDLE;
				end else if (!rate_ok) begin
					next_state = ST_REFUSED; // [RULE_05]
				end else begin
					next_state = ST_RUN;
				end
			end
			ST_REFUSED: begin
				// stays refused until software drops the request
				next_state = i_clocked_in_en ? ST_REFUSED : ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// rate_ok here blanks the pins on the very edge the rate rises,
	// before the state has moved to refused
	wire dio_capture = (state == ST_RUN) && rate_ok;
	assign o_clocked_in_active  = (state == ST_RUN);
	assign o_clocked_in_refused = (state == ST_REFUSED);

	// one strobe captures both channels and the pins together
	wire [`SAMPLE_W-1:0] ch0_fmt = to_twos(i_adc_ch0, i_adc_offset_binary);
	wire [`SAMPLE_W-1:0] ch1_fmt = to_twos(i_adc_ch1, i_adc_offset_binary);
	wire [`DIO_W-1:0]    dio_cap = dio_capture ? pin_value : '0;

	logic                 cap_valid;
	logic [`STREAM_W-1:0] cap_word;
	logic                 fifo_in_ready;

	// the capture stage is a ninth slot: a word the fifo refused waits
	// there, so a new sample is admitted only when that slot is free or
	// empties into the fifo on this same edge
	wire admit       = !cap_valid || fifo_in_ready;
	wire take_sample = i_adc_strobe && i_adc_enable && admit;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			cap_valid <= 1'b0;
			cap_word  <= '0;
		end else begin
			// a held word stays put until the fifo takes it
			cap_valid <= take_sample || (cap_valid && !fifo_in_ready);
			if (take_sample) begin
				cap_word[`STREAM_CH0_LSB +: `SAMPLE_W] <= ch0_fmt; // [RULE_08] [RULE_09]
				cap_word[`STREAM_CH1_LSB +: `SAMPLE_W] <= ch1_fmt; // [RULE_08] [RULE_09]
				cap_word[`STREAM_DIO_LSB +: `DIO_W]    <= dio_cap; // [RULE_04]
			end
		end
	end

	// eight fifo words plus the capture stage give nine words of slack
	acq_dio_fifo #(
		.WIDTH (`STREAM_W),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_srst      (i_srst),
		.i_in_valid  (cap_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (cap_word),
		.o_out_valid (o_stream_valid),
		.i_out_ready (i_stream_ready),
		.o_out_data  (o_stream_data)
	); // [RULE_04]

	assign o_adc_ready = admit;

	// converters cannot pause, so a strobe against a full fifo with the capture stage still held is lost;
	// it is counted and flagged rather than silently dropped
	wire overrun_event = i_adc_strobe && i_adc_enable && !admit;

	// the count saturates so a long stall cannot wrap it back to a
	// small and misleading number
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_overrun       <= 1'b0;
			o_overrun_count <= '0;
		end else begin
			if (overrun_event) begin
				o_overrun <= 1'b1;
			end else if (i_overrun_clear) begin
				o_overrun <= 1'b0;
			end
			if (overrun_event && (o_overrun_count != '1)) begin
				o_overrun_count <= o_overrun_count + 1'b1;
			end else if (i_overrun_clear && !overrun_event) begin
				o_overrun_count <= '0;
			end
		end
	end

	// output attenuators and analog input switches
	// switch drives are registered so relays see no decode glitches
	// 20 dB in the first bank is both the 6 dB and 14 dB sections in series
	wire atten1_6  = (i_atten1_sel == ATTEN1_6DB) ||
	                 (i_atten1_sel == ATTEN1_20DB);
	wire atten1_14 = (i_atten1_sel == ATTEN1_14DB) ||
	                 (i_atten1_sel == ATTEN1_20DB);
	wire atten2_20 = (i_atten2_sel == ATTEN2_20DB);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_atten1_6db  <= 1'b0;
			o_atten1_14db <= 1'b0;
			o_atten2_20db <= 1'b0;
			o_ain_term    <= '0;
			o_ain_ac      <= '0;
		end else begin
			o_atten1_6db  <= atten1_6; // [RULE_11]
			o_atten1_14db <= atten1_14; // [RULE_11]
			o_atten2_20db <= atten2_20; // [RULE_12]
			o_ain_term    <= i_ain_term_en; // [RULE_13]
			o_ain_ac      <= i_ain_ac_en; // [RULE_14]
		end
	end

endmodule : acq_dio

`default_nettype wire

// ===== inc/acq_dio_defs.svh
// constants for the digital port, sample format and switch control block
`ifndef ACQ_DIO_DEFS_SVH
`define ACQ_DIO_DEFS_SVH

`define DIO_PORT_W        8
`define DIO_PORTS         2
`define DIO_W             16
`define SAMPLE_W          12
`define STREAM_W          40
`define STREAM_CH0_LSB    0
`define STREAM_CH1_LSB    12
`define STREAM_DIO_LSB    24
`define DAC_WORD_W        28
`define DAC_SAMPLE_LSB    0
`define DAC_DIO_LSB       12
`define FIFO_DEPTH        8
`define CLK_RATE_HZ       32'd100000000
`define DIO_IN_MAX_RATE_HZ 32'd10000000
`define RATE_W            32
`define OVERRUN_W         16
`define DIO_RESET_DRIVE   16'h0000
`define DIO_RESET_DIR     2'b00

`endif

// ===== inc/acq_dio_pkg.sv
// types shared by the digital port block and its bench
package acq_dio_pkg;

	typedef enum logic [1:0] {
		ATTEN1_0DB,
		ATTEN1_6DB,
		ATTEN1_14DB,
		ATTEN1_20DB
	} atten1_sel_t;

	typedef enum logic {
		ATTEN2_BYPASS,
		ATTEN2_20DB
	} atten2_sel_t;

	typedef enum {
		ST_IDLE,
		ST_RUN,
		ST_REFUSED
	} stream_state_t;

endpackage : acq_dio_pkg

// ===== design/acq_dio_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module acq_dio_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clock,
	input  wire logic             i_srst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;

	wire push = i_in_valid && o_in_ready;
	wire pop  = o_out_valid && i_out_ready;

	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : bump

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= bump(rd_ptr);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : acq_dio_fifo

`default_nettype wire

// ===== dv/acq_dio_monitor.sv
// concurrent checks on the ports of the digital port block
`timescale 1ns/1ps
`default_nettype none
`include "acq_dio_defs.svh"
module acq_dio_monitor (
	input wire logic			i_clock,
	input wire logic			i_srst,
	input wire logic [15:0]		i_dio_pin,
	input wire logic [15:0]		o_dio_pin,
	input wire logic [15:0]		o_dio_pin_oe_n,
	input wire logic [1:0]		i_port_dir_out,
	input wire logic [1:0]		i_port_term_en,
	input wire logic [1:0]		o_port_term,
	input wire logic [1:0]		o_port_dir_out,
	input wire logic			i_read_req,
	input wire logic			o_read_valid,
	input wire logic [15:0]		o_read_data,
	input wire logic			i_write_req,
	input wire logic [15:0]		i_write_data,
	input wire logic			o_write_refused,
	input wire logic			i_clocked_in_en,
	input wire logic [31:0]		i_sample_rate_hz,
	input wire logic			o_clocked_in_active,
	input wire logic			i_adc_enable,
	input wire logic			i_adc_strobe,
	input wire logic [11:0]		i_adc_ch0,
	input wire logic [11:0]		i_adc_ch1,
	input wire logic			i_adc_offset_binary,
	input wire logic			o_adc_ready,
	input wire logic			o_stream_valid,
	input wire logic [39:0]		o_stream_data,
	input wire logic			i_clocked_out_en,
	input wire logic			i_dac_strobe,
	input wire logic [27:0]		i_dac1_word,
	input wire logic [11:0]		o_dac1_sample,
	input wire acq_dio_pkg::atten1_sel_t	i_atten1_sel,
	input wire acq_dio_pkg::atten2_sel_t	i_atten2_sel,
	input wire logic			o_atten1_6db,
	input wire logic			o_atten1_14db,
	input wire logic			o_atten2_20db
);
	import acq_dio_pkg::*;
	logic [11:0]	msb;
	logic [39:0]	exp_w;
	// the dio field is zero unless clocked input is running
	assign msb = {i_adc_offset_binary, 11'h000};
	assign exp_w = {o_clocked_in_active ? i_dio_pin : 16'h0000,
		i_adc_ch1 ^ msb, i_adc_ch0 ^ msb};
	function automatic logic [15:0] pick(logic [1:0] d, logic [15:0] v,
		logic [15:0] p);
		pick = {d[1] ? v[15:8] : p[15:8], d[0] ? v[7:0] : p[7:0]};
	endfunction : pick
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// a lone capture into an empty path, so the head is known exactly
	sequence cap_s;
		i_adc_strobe && i_adc_enable && o_adc_ready && !o_stream_valid &&
			!$past(i_adc_strobe);
	endsequence
	sequence word_s;
		##2 o_stream_valid && o_stream_data == $past(exp_w, 2);
	endsequence
	rst_drv_a: assert property ($fell(i_srst) |->
		o_dio_pin_oe_n == 16'hffff && o_port_dir_out == 2'b00)
		else $error("drivers not off after reset");
	port_oe_a: assert property (
		o_dio_pin_oe_n == {{8{!o_port_dir_out[1]}}, {8{!o_port_dir_out[0]}}})
		else $error("pin enables disagree with port direction");
	dir_follow_a: assert property (1 |=>
		o_port_dir_out == $past(i_port_dir_out))
		else $error("port direction not taken");
	read_data_a: assert property (i_read_req |=> o_read_valid &&
		o_read_data == $past(pick(o_port_dir_out, o_dio_pin, i_dio_pin)))
		else $error("single read wrong");
	write_now_a: assert property (
		i_write_req && !i_clocked_out_en && !i_dac_strobe |=>
		o_dio_pin == $past(i_write_data))
		else $error("single write not applied");
	write_ref_a: assert property (
		i_write_req && i_clocked_out_en && !i_dac_strobe |=>
		o_write_refused && $stable(o_dio_pin))
		else $error("write during clocked output not refused");
	dac_out_a: assert property (i_dac_strobe && i_clocked_out_en |=>
		o_dio_pin == $past(i_dac1_word[27:12]) &&
		o_dac1_sample == $past(i_dac1_word[11:0]))
		else $error("clocked output word wrong");
	rate_lim_a: assert property (o_clocked_in_active |->
		$past(i_clocked_in_en) &&
		$past(i_sample_rate_hz) <= `DIO_IN_MAX_RATE_HZ)
		else $error("clocked input running above rate limit");
	cap_word_a: assert property (cap_s |-> word_s)
		else $error("captured word wrong");
	atten_sel_a: assert property (1 |=>
		o_atten1_6db == ($past(i_atten1_sel) inside {ATTEN1_6DB, ATTEN1_20DB}) &&
		o_atten1_14db == ($past(i_atten1_sel) inside {ATTEN1_14DB, ATTEN1_20DB}) &&
		o_atten2_20db == ($past(i_atten2_sel) == ATTEN2_20DB))
		else $error("attenuator switches wrong");
	port_term_a: assert property (!$past(i_srst) &&
		$stable(i_port_dir_out) |=>
		o_port_term == ($past(i_port_term_en) & ~o_port_dir_out))
		else $error("port termination wrong");
endmodule : acq_dio_monitor
bind acq_dio acq_dio_monitor u_acq_dio_monitor (.*);
`default_nettype wire

// ===== dv/acq_dio_far.sv
// far side: external pin drivers and a host stream sink that can stall
`timescale 1ns/1ps
`default_nettype none
module acq_dio_far (
	input wire logic		i_ext_en,
	input wire logic [15:0]	i_ext,
	input wire logic [15:0]	i_drive,
	input wire logic [15:0]	i_oe_n,
	input wire logic		i_go,
	input wire logic		i_stall,
	output logic [15:0]		o_pin,
	output logic			o_ready
);
	// a pin the block drives shows the drive, others the outside level
	assign o_pin = (i_oe_n & i_ext & {16{i_ext_en}}) | (~i_oe_n & i_drive);
	// slow host: ready follows the pattern unless held off
	assign o_ready = i_go & ~i_stall;
endmodule : acq_dio_far
`default_nettype wire

// ===== dv/tb_acq_dio.sv
// self-checking bench for the digital port block
`timescale 1ns/1ps
`default_nettype none
module tb_acq_dio;
	import acq_dio_pkg::*;
	logic i_clock, i_srst, i_read_req, i_write_req, i_clocked_in_en;
	logic i_adc_enable, i_adc_strobe, i_adc_offset_binary, i_stream_ready;
	logic i_overrun_clear, i_clocked_out_en, i_dac_strobe, go, stall;
	logic o_read_valid, o_write_refused, o_clocked_in_active, o_overrun;
	logic o_clocked_in_refused, o_adc_ready, o_stream_valid;
	logic o_atten1_6db, o_atten1_14db, o_atten2_20db;
	logic [15:0] i_dio_pin, o_dio_pin, o_dio_pin_oe_n, o_read_data, ext;
	logic [15:0] i_write_data, o_overrun_count, drv;
	logic [1:0] i_port_dir_out, i_port_term_en, o_port_term, o_port_dir_out;
	logic [1:0] i_ain_term_en, i_ain_ac_en, o_ain_term, o_ain_ac;
	logic [31:0] i_sample_rate_hz;
	logic [11:0] i_adc_ch0, i_adc_ch1, o_dac1_sample;
	logic [39:0] o_stream_data;
	logic [27:0] i_dac1_word;
	atten1_sel_t i_atten1_sel;
	atten2_sel_t i_atten2_sel;
	int error_cnt = 0;
	int cmp_count = 0;
	int lost = 0;
	integer seed = 32'h47b14345;
	logic [39:0] q[$];
	acq_dio u_acq_dio (.*);
	acq_dio_far u_acq_dio_far (.i_ext_en(1'b1), .i_ext(ext), .i_drive(o_dio_pin),
		.i_oe_n(o_dio_pin_oe_n), .i_go(go), .i_stall(stall),
		.o_pin(i_dio_pin), .o_ready(i_stream_ready));
	task automatic chk(input string n, input logic [39:0] s, e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic test_done;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task automatic tk(input int n);
		repeat (n) @(negedge i_clock);
	endtask : tk
	// stream model: each taken strobe queues the word the host should see
	always @(posedge i_clock) begin
		if (!i_srst && i_adc_strobe && i_adc_enable) begin
			if (o_adc_ready)
				q.push_back({o_clocked_in_active ? i_dio_pin : 16'h0000,
					i_adc_ch1 ^ {i_adc_offset_binary, 11'h000},
					i_adc_ch0 ^ {i_adc_offset_binary, 11'h000}});
			else
				lost++;
		end
		if (!i_srst && o_stream_valid && i_stream_ready)
			chk("stream", o_stream_data, q.size() ? q.pop_front() : 40'h0);
	end
	initial begin
		i_clock = 0;
		forever #5 i_clock = ~i_clock;
	end
	initial begin
		repeat (5000) @(posedge i_clock);
		error_cnt++;
		test_done;
	end
	initial begin
		{i_read_req, i_write_req, i_clocked_in_en, i_adc_enable} = '0;
		{i_adc_strobe, i_adc_offset_binary, i_overrun_clear} = '0;
		{i_clocked_out_en, i_dac_strobe, stall, i_write_data} = '0;
		{i_port_dir_out, i_port_term_en, i_ain_term_en, i_ain_ac_en} = '0;
		{i_sample_rate_hz, i_adc_ch0, i_adc_ch1, i_dac1_word} = '0;
		i_atten1_sel = ATTEN1_0DB;
		i_atten2_sel = ATTEN2_BYPASS;
		i_srst = 1;
		go = 1;
		ext = 16'($random(seed));
		tk(8);
		i_srst = 0;
		tk(1);
		chk("oe reset", o_dio_pin_oe_n, 16'hffff);
		chk("dir reset", o_port_dir_out, 2'b00);
		for (int d = 0; d < 4; d++) begin
			i_port_dir_out = d[1:0];
			i_port_term_en = 2'($random(seed));
			ext = 16'($random(seed));
			i_write_req = 1;
			i_write_data = 16'($random(seed));
			drv = i_write_data;
			tk(1);
			i_write_req = 0;
			tk(1);
			chk("oe", o_dio_pin_oe_n, {{8{~d[1]}}, {8{~d[0]}}});
			chk("term", o_port_term, i_port_term_en & ~d[1:0]);
			chk("drive", o_dio_pin, drv);
			i_read_req = 1;
			tk(1);
			i_read_req = 0;
			chk("rd valid", o_read_valid, 1'b1);
			chk("rd", o_read_data, {d[1] ? drv[15:8] : ext[15:8],
				d[0] ? drv[7:0] : ext[7:0]});
		end
		i_clocked_out_en = 1;
		i_write_req = 1;
		i_write_data = ~drv;
		tk(1);
		i_write_req = 0;
		chk("refused", o_write_refused, 1'b1);
		chk("held", o_dio_pin, drv);
		for (int k = 0; k < 6; k++) begin
			i_dac_strobe = 1;
			i_dac1_word = 28'($random(seed));
			tk(1);
			chk("dac", {o_dio_pin, o_dac1_sample}, i_dac1_word);
		end
		{i_dac_strobe, i_clocked_out_en} = '0;
		for (int a = 0; a < 8; a++) begin
			i_atten1_sel = atten1_sel_t'(a[1:0]);
			i_atten2_sel = atten2_sel_t'(a[2]);
			i_ain_term_en = a[1:0];
			i_ain_ac_en = ~a[2:1];
			tk(1);
			chk("atten", {o_atten1_6db, o_atten1_14db, o_atten2_20db},
				{a[0], a[1], a[2]});
			chk("ain", {o_ain_term, o_ain_ac}, {a[1:0], ~a[2:1]});
		end
		i_clocked_in_en = 1;
		i_sample_rate_hz = 32'd10000001;
		tk(2);
		chk("over rate", {o_clocked_in_active, o_clocked_in_refused}, 2'b01);
		i_sample_rate_hz = 32'd10000000;
		tk(2);
		chk("stay refused", {o_clocked_in_active, o_clocked_in_refused}, 2'b01);
		i_clocked_in_en = 0;
		tk(1);
		i_clocked_in_en = 1;
		tk(2);
		chk("at limit", {o_clocked_in_active, o_clocked_in_refused}, 2'b10);
		i_port_dir_out = 2'b10;
		i_adc_enable = 1;
		// the host holds off mid-run while strobes keep coming, forcing loss
		for (int k = 0; k < 40; k++) begin
			stall = k > 20 && k < 34;
			i_adc_strobe = stall | 1'($random(seed));
			i_adc_ch0 = 12'($random(seed));
			i_adc_ch1 = 12'($random(seed));
			i_adc_offset_binary = k[3];
			ext = 16'($random(seed));
			go = 1'($random(seed));
			i_clocked_in_en = k < 30;
			tk(1);
		end
		{i_adc_strobe, stall} = '0;
		go = 1;
		tk(20);
		chk("overrun", o_overrun, 1'b1);
		chk("lost", o_overrun_count, 40'(lost));
		chk("some lost", lost > 0, 1'b1);
		chk("drained", q.size(), 40'h0);
		i_overrun_clear = 1;
		tk(1);
		i_overrun_clear = 0;
		tk(1);
		chk("ovr clear", {o_overrun, o_overrun_count}, 17'h0);
		// a rate rise while running must move the stream to refused
		i_clocked_in_en = 1;
		i_sample_rate_hz = 32'd10000000;
		tk(2);
		i_sample_rate_hz = 32'd10000001;
		tk(1);
		chk("rate rise", {o_clocked_in_active, o_clocked_in_refused},
			2'b01);
		test_done;
	end
endmodule : tb_acq_dio
`default_nettype wire
